// file: design/rx_recovery_pkg.sv
// Package: constants and carrier types for the serial receive recovery block
package rx_recovery_pkg;

  // ------------------------------------------------------------
  // Sampling
  // ------------------------------------------------------------
  localparam logic [3:0] SAMPLES_NORMAL_LAST = 4'hf;  // 16 states per bit
  localparam logic [3:0] SAMPLES_DOUBLE_LAST = 4'h7;  // 8 states per bit
  localparam logic [3:0] VOTE_FIRST_NORMAL   = 4'h8;  // samples 8,9,10
  localparam logic [3:0] VOTE_FIRST_DOUBLE   = 4'h4;  // samples 4,5,6
  localparam logic [3:0] VOTE_LAST_NORMAL    = 4'ha;
  localparam logic [3:0] VOTE_LAST_DOUBLE    = 4'h6;
  localparam logic [3:0] SAMPLE_ONE          = 4'h1;
  localparam logic [3:0] SAMPLE_ZERO         = 4'h0;

  // ------------------------------------------------------------
  // Frame format
  // ------------------------------------------------------------
  localparam int         DATA_W       = 9;
  localparam logic [3:0] BITS_MIN     = 4'h5;
  localparam logic [2:0] SIZE_NINE    = 3'h7;   // Character size code for nine bits
  localparam logic [3:0] BITS_NINE    = 4'h9;
  localparam logic [3:0] BIT_IDX_ZERO = 4'h0;
  localparam logic [1:0] VOTE_ZERO    = 2'h0;
  localparam logic [1:0] VOTE_MAJOR   = 2'h2;
  localparam logic [DATA_W-1:0] DATA_ZERO = 9'h000;

  // ------------------------------------------------------------
  // Buffer
  // ------------------------------------------------------------
  localparam int         BUF_DEPTH = 2;
  localparam logic [1:0] CNT_EMPTY = 2'h0;
  localparam logic [1:0] CNT_FULL  = 2'h2;

  // ------------------------------------------------------------
  // Types
  // ------------------------------------------------------------
  typedef enum logic [4:0] {
    ST_IDLE   = 5'b00001,
    ST_START  = 5'b00010,
    ST_DATA   = 5'b00100,
    ST_PARITY = 5'b01000,
    ST_STOP   = 5'b10000
  } rx_state_e;

  typedef struct packed {
    logic [DATA_W-1:0] data;         // Bit 8 is the ninth bit
    logic              frame_err;
    logic              overrun;
    logic              parity_err;
  } rx_frame_s;

  typedef struct packed {
    logic       rx_enable_bit;
    logic       double_speed_bit;
    logic       parity_enable_bit;
    logic       parity_type_bit;
    logic       stop_bit_count_select;
    logic [2:0] char_size;           // 0..3 = 5..8 bits, 7 = nine bits
  } rx_config_s;

endpackage : rx_recovery_pkg

// file: design/uart_receiver_recovery.sv
// Asynchronous serial receiver: start detection, bit recovery, two-entry buffer
module uart_receiver_recovery
  import rx_recovery_pkg::*;
(
  // Clock and reset
  input  wire  logic                       core_clk,
  input  wire  logic                       reset,
  // Configuration
  input  wire  rx_recovery_pkg::rx_config_s cfg,
  input  wire  logic                       rx_complete_irq_enable,
  input  wire  logic                       global_irq_enable,
  input  wire  logic                       sample_tick,
  // Serial line
  input  wire  logic                       serial_in_pin,
  // Software side
  input  wire  logic                       data_read,
  output logic [8:0]                       serial_data_reg,
  output logic                             rx_ninth_bit,
  output logic                             rx_complete,
  output logic                             frame_error_flag,
  output logic                             overrun_flag,
  output logic                             parity_error_flag,
  output logic                             rx_irq,
  output logic                             pin_override
);
  import rx_recovery_pkg::*;

  // ------------------------------------------------------------
  // Input synchroniser
  // ------------------------------------------------------------
  // Two flops before any logic reads the pin; the two cycles of delay
  // stay well inside one sample period
  logic        meta_ff;
  logic        line_ff;

  always_ff @(posedge core_clk) begin
    meta_ff <= serial_in_pin;
    line_ff <= meta_ff;
  end

  // ------------------------------------------------------------
  // Sample timing
  // ------------------------------------------------------------
  rx_state_e   state_ff, nxt_state;
  logic [3:0]  sample_ff;
  logic [1:0]  votes_ff;
  logic [3:0]  bit_idx_ff;
  logic [8:0]  shift_ff;
  logic        par_ff;
  logic        prev_high_ff;
  logic        pend_ff;
  rx_frame_s   pend_frame_ff;
  logic        lost_ff;

  wire         enabled    = cfg.rx_enable_bit;
  wire [3:0]   last_samp  = cfg.double_speed_bit ? SAMPLES_DOUBLE_LAST
                                                 : SAMPLES_NORMAL_LAST;
  wire [3:0]   vote_first = cfg.double_speed_bit ? VOTE_FIRST_DOUBLE : VOTE_FIRST_NORMAL;
  wire [3:0]   vote_last  = cfg.double_speed_bit ? VOTE_LAST_DOUBLE : VOTE_LAST_NORMAL;
  // The counter holds the previous sample's number when a tick arrives,
  // so the sample being taken is one further on
  wire [3:0]   samp_num   = sample_ff + SAMPLE_ONE;
  wire         in_vote    = (samp_num >= vote_first) && (samp_num <= vote_last);
  wire         vote_done  = sample_tick && (samp_num == vote_last);
  wire         bit_end    = sample_tick && (sample_ff == last_samp);
  wire [1:0]   votes_nxt  = votes_ff + {1'b0, line_ff & in_vote};
  wire         bit_value  = (votes_nxt >= VOTE_MAJOR);
  wire [3:0]   data_bits  = (cfg.char_size == SIZE_NINE) ? BITS_NINE
                          : BITS_MIN + {1'b0, cfg.char_size};
  // Index has already moved past a bit by the time that bit ends
  wire         last_data  = (bit_idx_ff == data_bits);
  // Only a high-to-low step starts a frame; a line held low starts one only on the first tick after reset or enable
  wire         fall_seen  = (state_ff == ST_IDLE) && sample_tick && !line_ff
                          && prev_high_ff;
  wire         start_ok   = (state_ff == ST_START) && vote_done && !bit_value;
  wire         start_bad  = (state_ff == ST_START) && vote_done && bit_value;
  // Stop bit ends at its last vote sample so the next start can follow at once
  wire         stop_done  = (state_ff == ST_STOP) && vote_done;
  wire         data_end   = bit_end && last_data;
  rx_state_e   after_data;

  // Parity is skipped when checking is off
  assign after_data = cfg.parity_enable_bit ? ST_PARITY : ST_STOP;

  // ------------------------------------------------------------
  // Previous sample level
  // ------------------------------------------------------------
  // Starts at the idle level, so a line already low after reset or enable reads as a falling edge
  always_ff @(posedge core_clk) begin
    if (reset || !enabled) begin
      prev_high_ff <= 1'b1;
    end else if (sample_tick) begin
      prev_high_ff <= line_ff;
    end
  end

  // ------------------------------------------------------------
  // State machine
  // ------------------------------------------------------------
  // A second stop bit is never waited for; that is what lets a new
  // start follow right after the first stop bit's vote
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      ST_IDLE: begin
        if (fall_seen) begin
          nxt_state = ST_START;
        end
      end
      ST_START: begin
        if (start_bad) begin
          nxt_state = ST_IDLE;
        end else if (start_ok) begin
          nxt_state = ST_DATA;
        end
      end
      ST_DATA: begin
        if (data_end) begin
          nxt_state = after_data;
        end
      end
      ST_PARITY: begin
        if (bit_end) begin
          nxt_state = ST_STOP;
        end
      end
      ST_STOP: begin
        if (stop_done) begin
          nxt_state = ST_IDLE;
        end
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (reset || !enabled) begin
      state_ff <= ST_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Sample counter restarts at 1 on the first low sample of each start
  always_ff @(posedge core_clk) begin
    if (reset || !enabled) begin
      sample_ff <= SAMPLE_ZERO;
      votes_ff  <= VOTE_ZERO;
    end else if (fall_seen) begin
      sample_ff <= SAMPLE_ONE;
      votes_ff  <= VOTE_ZERO;
    end else if (sample_tick && state_ff != ST_IDLE) begin
      sample_ff <= bit_end ? SAMPLE_ZERO : sample_ff + 4'h1;
      votes_ff  <= (bit_end || vote_done) ? VOTE_ZERO : votes_nxt;
    end
  end

  // ------------------------------------------------------------
  // Shift register and parity
  // ------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (reset || start_ok) begin
      bit_idx_ff   <= BIT_IDX_ZERO;
      shift_ff     <= DATA_ZERO;
      par_ff       <= 1'b0;
    end else if (vote_done && state_ff == ST_DATA) begin
      shift_ff[bit_idx_ff] <= bit_value;
      bit_idx_ff           <= bit_idx_ff + 4'h1;
      par_ff               <= par_ff ^ bit_value;
    end else if (vote_done && state_ff == ST_PARITY) begin
      // Even when type is zero, odd when one
      par_ff       <= par_ff ^ bit_value ^ cfg.parity_type_bit;
    end
  end

  // ------------------------------------------------------------
  // Pending frame register, overrun tracking
  // ------------------------------------------------------------
  logic [1:0]  count_ff;
  wire         buf_ready  = (count_ff != CNT_FULL);
  wire         push       = pend_ff && buf_ready;
  wire         pop        = data_read && (count_ff != CNT_EMPTY);
  wire         overrun_ev = pend_ff && !buf_ready && fall_seen;

  always_ff @(posedge core_clk) begin
    if (reset || !enabled) begin
      pend_ff       <= 1'b0;
      pend_frame_ff <= '0;
      lost_ff       <= 1'b0;
    end else begin
      if (overrun_ev) begin
        // Waiting frame dropped; buffer contents untouched
        pend_ff <= 1'b0;
        lost_ff <= 1'b1;
      end else if (stop_done) begin
        pend_ff                  <= 1'b1;
        pend_frame_ff.data       <= shift_ff;
        // Stop bit is judged from its own vote, taken in this very cycle
        pend_frame_ff.frame_err  <= !bit_value;
        pend_frame_ff.parity_err <= cfg.parity_enable_bit & par_ff;
        pend_frame_ff.overrun    <= lost_ff;
      end else if (push) begin
        pend_ff <= 1'b0;
        lost_ff <= 1'b0;
      end
      if (stop_done && overrun_ev) begin
        pend_ff <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------
  // Two-entry receive buffer
  // ------------------------------------------------------------
  rx_frame_s   mem_ff [BUF_DEPTH];
  logic        wr_ptr_ff;
  logic        rd_ptr_ff;
  rx_frame_s   store_frame;
  rx_frame_s   head_frame;

  always_comb begin
    store_frame         = pend_frame_ff;
    store_frame.overrun = pend_frame_ff.overrun | lost_ff;
  end

  always_ff @(posedge core_clk) begin
    if (reset || !enabled) begin
      wr_ptr_ff <= 1'b0;
      rd_ptr_ff <= 1'b0;
      count_ff  <= CNT_EMPTY;
    end else begin
      if (push) begin
        mem_ff[wr_ptr_ff] <= store_frame;
        wr_ptr_ff         <= ~wr_ptr_ff;
      end
      if (pop) begin
        rd_ptr_ff <= ~rd_ptr_ff;
      end
      count_ff <= count_ff + {1'b0, push} - {1'b0, pop};
    end
  end

  // ------------------------------------------------------------
  // Registered outputs
  // ------------------------------------------------------------
  logic [1:0]  nxt_count;
  logic        nxt_rd;
  assign nxt_count = (reset || !enabled) ? CNT_EMPTY
                   : count_ff + {1'b0, push} - {1'b0, pop};
  assign nxt_rd    = pop ? ~rd_ptr_ff : rd_ptr_ff;

  // A frame written in this cycle is not yet in storage, so it is taken
  // straight from the pending register when it becomes the head
  wire         head_empty = (nxt_count == CNT_EMPTY);
  wire         head_new   = push && ((count_ff == CNT_EMPTY) || pop);

  always_comb begin
    head_frame = '0;
    if (head_empty) begin
      head_frame = '0;
    end else if (head_new) begin
      head_frame = store_frame;
    end else begin
      head_frame = mem_ff[nxt_rd];
    end
  end

  // ------------------------------------------------------------
  // Status view of the head frame
  // ------------------------------------------------------------
  wire [8:0]   view_data  = head_frame.data;
  wire         view_ninth = head_frame.data[8];
  wire         view_fe    = head_frame.frame_err;
  wire         view_ov    = head_frame.overrun;
  wire         view_pe    = head_frame.parity_err;
  wire         view_full  = !head_empty;
  // Only the complete flag feeds the request; error flags have no path here
  wire         view_irq   = rx_complete_irq_enable && global_irq_enable && view_full;

  // Error flags are outputs only; no write path exists for them
  always_ff @(posedge core_clk) begin
    if (reset) begin
      serial_data_reg   <= DATA_ZERO;
      rx_ninth_bit      <= 1'b0;
      frame_error_flag  <= 1'b0;
      overrun_flag      <= 1'b0;
      parity_error_flag <= 1'b0;
    end else begin
      serial_data_reg   <= view_data;
      rx_ninth_bit      <= view_ninth;
      frame_error_flag  <= view_fe;
      overrun_flag      <= view_ov;
      parity_error_flag <= view_pe;
    end
  end

  // Complete flag, request and pin ownership
  always_ff @(posedge core_clk) begin
    if (reset) begin
      rx_complete  <= 1'b0;
      rx_irq       <= 1'b0;
      pin_override <= 1'b0;
    end else begin
      rx_complete  <= view_full;
      rx_irq       <= view_irq;
      pin_override <= enabled;
    end
  end

endmodule // uart_receiver_recovery

// file: testbench/rx_recovery_checker.sv
// Checker: port properties of the serial receive recovery block
module rx_recovery_checker
  import rx_recovery_pkg::*;
(
  // Clock and reset
  input wire logic                        core_clk,
  input wire logic                        reset,
  // Controls
  input wire rx_recovery_pkg::rx_config_s cfg,
  input wire logic                        rx_complete_irq_enable,
  input wire logic                        global_irq_enable,
  input wire logic                        data_read,
  // Results
  input wire logic [8:0]                  serial_data_reg,
  input wire logic                        rx_ninth_bit,
  input wire logic                        rx_complete,
  input wire logic                        frame_error_flag,
  input wire logic                        overrun_flag,
  input wire logic                        parity_error_flag,
  input wire logic                        rx_irq,
  input wire logic                        pin_override
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);

  AST_IRQ_SOURCE: assert property (rx_irq |-> $past(rx_complete_irq_enable && global_irq_enable)
    && ($past(rx_complete) || rx_complete)) else $error("irq without cause");
  AST_IRQ_HOLD: assert property (rx_complete && $past(rx_complete)
    && $past(rx_complete_irq_enable && global_irq_enable) |-> rx_irq) else $error("irq missing");
  AST_FLUSH: assert property (!cfg.rx_enable_bit |=> !rx_complete && !pin_override)
    else $error("disable did not flush");
  AST_PIN_OWN: assert property (cfg.rx_enable_bit [*2] |-> pin_override)
    else $error("pin not owned");
  AST_HEAD_STABLE: assert property (rx_complete && $past(rx_complete) && !$past(data_read)
    |-> $stable(serial_data_reg) && $stable({frame_error_flag, overrun_flag, parity_error_flag}))
    else $error("head changed without read");
  AST_COMPLETE_FALL: assert property ($fell(rx_complete)
    |-> $past(data_read) || !$past(cfg.rx_enable_bit)) else $error("complete fell alone");
  AST_NINTH: assert property (rx_complete |-> rx_ninth_bit == serial_data_reg[8])
    else $error("ninth bit mismatch");
  AST_MASK: assert property (rx_complete && cfg.char_size <= 3'h3
    |-> (serial_data_reg >> (4'h5 + cfg.char_size)) == 9'h000) else $error("upper bits set");
  AST_PAR_OFF: assert property (rx_complete && !cfg.parity_enable_bit |-> !parity_error_flag)
    else $error("parity error while unchecked");
endmodule // rx_recovery_checker

bind uart_receiver_recovery rx_recovery_checker u_chk (.core_clk, .reset, .cfg,
  .rx_complete_irq_enable, .global_irq_enable, .data_read, .serial_data_reg, .rx_ninth_bit,
  .rx_complete, .frame_error_flag, .overrun_flag, .parity_error_flag, .rx_irq, .pin_override);

// file: testbench/rx_line_model.sv
// Partner: remote serial transmitter driving the receive line
module rx_line_model
  import rx_recovery_pkg::*;
(
  // Clock and tick
  input  wire logic core_clk,
  input  wire logic sample_tick,
  // Serial line
  output logic      serial_in_pin
);
  timeunit 1ns;
  timeprecision 100ps;

  initial serial_in_pin = 1'b1;

  // Holds a level for n sample ticks, aligned to the receiver's ticks
  task automatic hold(input logic v, input int n);
    serial_in_pin = v;
    repeat (n) @(posedge core_clk iff sample_tick);
    #1;
  endtask

  // Stop held sl ticks; a short stop with no gap gives the earliest next start
  task automatic send(input logic [8:0] d, input int nb, input logic pe, pb, stop,
                      input int spb, sl, gap);
    hold(1'b1, 1);
    hold(1'b0, spb);
    for (int i = 0; i < nb; i++) hold(d[i], spb);
    if (pe) hold(pb, spb);
    hold(stop, sl);
    if (gap > 0) hold(1'b1, gap);
  endtask

  // Low for three samples only: too short to pass the start vote
  task automatic glitch(input int spb);
    hold(1'b1, 1);
    hold(1'b0, 3);
    hold(1'b1, 2 * spb);
  endtask
endmodule // rx_line_model

// file: testbench/uart_receiver_recovery_test.sv
// Testbench: frames, errors, overrun and flush through the receive recovery block
module uart_receiver_recovery_test import rx_recovery_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
  logic       core_clk = 1'b0, reset = 1'b1, sample_tick = 1'b0, data_read = 1'b0;
  logic       rx_complete_irq_enable = 1'b0, global_irq_enable = 1'b0, auto_read = 1'b0;
  rx_config_s cfg = '0;
  logic       serial_in_pin, rx_ninth_bit, rx_complete, frame_error_flag, overrun_flag;
  logic       parity_error_flag, rx_irq, pin_override;
  logic [8:0] serial_data_reg;
  logic [1:0] tick_cnt = 2'h0;
  int         fail_count = 0, check_count = 0, cycles = 0, seed;
  rx_frame_s  exp_q[$];

  uart_receiver_recovery u_uart_receiver_recovery (.core_clk, .reset, .cfg,
    .rx_complete_irq_enable, .global_irq_enable, .sample_tick, .serial_in_pin, .data_read,
    .serial_data_reg, .rx_ninth_bit, .rx_complete, .frame_error_flag, .overrun_flag,
    .parity_error_flag, .rx_irq, .pin_override);
  rx_line_model u_rx_line_model (.core_clk, .sample_tick, .serial_in_pin);

  initial forever #4 core_clk = ~core_clk;
  // Tick every fourth cycle: slower than the two-flop synchroniser
  always @(posedge core_clk) begin
    tick_cnt <= tick_cnt + 2'h1;
    sample_tick <= #1 (tick_cnt == 2'h3);
    cycles++;
    if (cycles == 60000) begin
      fail_count++;
      give_verdict();
    end
  end

  task automatic check(input string what, input logic [11:0] exp, input logic [11:0] got);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic give_verdict();
    $display("checks %0d errors %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic settle();
    for (int n = 0; n < 3000 && (exp_q.size() != 0 || rx_complete !== 1'b0); n++) begin
      @(posedge core_clk);
      #1;
    end
  endtask

  task automatic send_one(input logic [2:0] sz, input logic pe, pt, ds, early, keep, ov);
    int nb, spb;
    logic [8:0] d;
    logic stop, bad;
    nb = (sz == SIZE_NINE) ? 9 : 5 + int'(sz);
    spb = ds ? 8 : 16;
    d = 9'($urandom) & 9'((1 << nb) - 1);
    stop = ($urandom % 4) != 0;
    bad = 1'($urandom);
    cfg.char_size = sz;
    cfg.parity_enable_bit = pe;
    cfg.parity_type_bit = pt;
    cfg.double_speed_bit = ds;
    cfg.stop_bit_count_select = 1'($urandom);
    {rx_complete_irq_enable, global_irq_enable} = 2'($urandom);
    if (keep) exp_q.push_back('{d, !stop, ov, pe & bad});
    u_rx_line_model.send(d, nb, pe, ^d ^ pt ^ bad, stop, spb,
                         early ? spb / 2 + 1 : spb, early ? 0 : spb);
  endtask

  // Reads and compares whenever a character waits and auto_read is set
  initial begin : monitor
    rx_frame_s e;
    forever begin
      @(posedge core_clk);
      #1;
      if (auto_read && rx_complete === 1'b1) begin
        e = exp_q.size() != 0 ? exp_q.pop_front() : rx_frame_s'('1);
        check("frame", e, {serial_data_reg, frame_error_flag, overrun_flag, parity_error_flag});
        check("ninth", {11'h0, e.data[8]}, {11'h0, rx_ninth_bit});
        // Status flags are never written by the bench
        data_read = 1'b1;  // One-cycle read pulse pops one character
        @(posedge core_clk);
        #1 data_read = 1'b0;
      end
    end
  end

  initial begin : main
    seed = $urandom(68130);
    repeat (3) @(posedge core_clk);
    #1 reset = 1'b0;
    repeat (2) @(posedge core_clk);
    #1 cfg.rx_enable_bit = 1'b1;
    auto_read = 1'b1;
    for (int m = 0; m < 12; m++) begin
      settle();
      send_one(m % 5 == 4 ? SIZE_NINE : 3'(m % 5), m[0], m[1], m >= 10, 0, 1, 0);
    end
    settle();
    u_rx_line_model.glitch(16);
    send_one(3'h3, 0, 0, 0, 0, 1, 0);
    for (int k = 0; k < 4; k++) begin
      if (k == 2) settle();  // Speed changes only between frames
      send_one(3'h3, 1, 0, k[1], 1, 1, 0);
    end
    settle();
    auto_read = 1'b0;
    for (int k = 0; k < 4; k++) send_one(3'h3, 0, 0, 0, 0, k != 2, k == 3);
    auto_read = 1'b1;
    send_one(3'h3, 0, 0, 0, 0, 1, 0);
    settle();
    auto_read = 1'b0;
    for (int k = 0; k < 2; k++) send_one(3'h3, 0, 0, 0, 0, 0, 0);
    check("complete", 12'h1, {11'h0, rx_complete});
    fork
      send_one(3'h3, 0, 0, 0, 0, 0, 0);
      begin
        repeat (200) @(posedge core_clk);
        #1 cfg.rx_enable_bit = 1'b0;
      end
    join
    check("flushed", 12'h0, {10'h0, rx_complete, pin_override});
    cfg.rx_enable_bit = 1'b1;
    auto_read = 1'b1;
    send_one(3'h3, 1, 1, 0, 0, 1, 0);
    settle();
    check("leftover", 12'h0, 12'(exp_q.size()));
    give_verdict();
  end
endmodule // uart_receiver_recovery_test
